// ===== core/step_defs.svh
`ifndef STEP_DEFS_SVH
`define STEP_DEFS_SVH
// Timing figures in ns, and cycle counts at the mclk rate.
`define MCLK_PERIOD_NS     25
`define STEP_PULSE_MIN_NS  2000
`define STEP_PULSE_CYC     ((`STEP_PULSE_MIN_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define WAKE_DELAY_NS      100000
`define WAKE_DELAY_CYC     ((`WAKE_DELAY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define RESET_PULSE_NS     2000
`define RESET_PULSE_CYC    ((`RESET_PULSE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define RESET_GAP_NS       5000
`define RESET_GAP_CYC      ((`RESET_GAP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS + 1)
// Input noise filter: a level must stand this many cycles to be accepted.
`define FILT_LEN           8
// Ring position holding both phases at code 8, positive polarity.
`define RING_START         6'h00
`define RING_SIZE          64
`define CODE_8             4'h8
`define CODE_F             4'hf
`define CODE_OFF           4'h0
// Mode select codes, {sel_2, sel_1, sel_0}.
`define MODE_FULL_8        3'h0
`define MODE_FULL_F        3'h1
`define MODE_HALF          3'h2
`define MODE_HALF_F        3'h3
`define MODE_QUARTER       3'h4
`define MODE_EIGHTH        3'h5
`define MODE_SIXTEENTH     3'h6
`define MODE_DEEP_SLEEP    3'h7
// Host side register offsets on AHB-Lite.
`define REG_CTRL           32'h0000_0000
`define REG_STEP           32'h0000_0004
`define REG_STATUS         32'h0000_0008
`define REG_PHASE          32'h0000_000c
`endif

// ===== core/step_host.sv
`timescale 1ns/1ps
`include "step_defs.svh"
// Host end: software writes CTRL (mode, direction, sleeps, sync), and
// writes STEP with a count; the host emits that many step pulses.
module step_host
	import step_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	step_link_if.host        link
);
	host_state_t state;
	logic [7:0]  ctrl;
	logic [15:0] steps_left;
	logic [15:0] cnt;
	logic        ph_wr;
	logic [31:0] ph_addr;
	logic        mon_a;
	logic        mon_b;
	logic [15:0] wake_cnt;
	logic        sleep_was;

	wire take      = hsel & hready & htrans[1];
	wire wr_ctrl   = ph_wr && (ph_addr == `REG_CTRL);
	wire busy      = (state != ST_IDLE) || (steps_left != 16'h0);
	wire wr_step   = ph_wr && (ph_addr == `REG_STEP) && !busy;
	wire sleep_now = ctrl[4] || (ctrl[2:0] == `MODE_DEEP_SLEEP);

	// Leaving either sleep holds off the next pulse out of IDLE for the wake delay;
	// a count written meanwhile simply waits in IDLE until it expires.
	always_ff @(posedge mclk) begin
		if (srst) begin
			wake_cnt  <= 16'h0;
			sleep_was <= 1'b0;
		end else begin
			sleep_was <= sleep_now;
			if (sleep_was && !sleep_now)
				wake_cnt <= 16'(`WAKE_DELAY_CYC);
			else if (wake_cnt != 16'h0)
				wake_cnt <= wake_cnt - 16'h1;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge mclk) begin
		if (srst) begin
			ph_wr   <= 1'b0;
			ph_addr <= 32'h0;
			hrdata  <= 32'h0;
			mon_a   <= 1'b0;
			mon_b   <= 1'b0;
		end else begin
			ph_wr   <= take & hwrite;
			ph_addr <= haddr;
			mon_a   <= link.two_phase_monitor;
			mon_b   <= mon_a;
			if (take && !hwrite) begin
				case (haddr)
					`REG_CTRL:   hrdata <= {24'h0, ctrl};
					`REG_STEP:   hrdata <= {16'h0, steps_left};
					`REG_STATUS: hrdata <= {30'h0, mon_b, busy};
					default:     hrdata <= 32'h0;
				endcase
			end
		end
	end

	// Ctrl: [2:0] mode, [3] dir, [4] light sleep, [5] sync, [6] reset.
	// A reset request written in IDLE runs a timed pulse plus the release gap.
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl       <= 8'h00;
			state      <= ST_IDLE;
			steps_left <= 16'h0;
			cnt        <= 16'h0;
		end else begin
			if (wr_ctrl)
				ctrl <= hwdata[7:0];
			case (state)
				ST_IDLE: begin
					cnt <= 16'h0;
					if (wr_ctrl && hwdata[6])
						state <= ST_RESET;
					else if (wr_step)
						steps_left <= hwdata[15:0];
					else if (steps_left != 16'h0 && wake_cnt == 16'h0)
						state <= ST_HIGH;
				end
				ST_HIGH: begin
					cnt <= cnt + 16'h1;
					if (cnt == 16'(`STEP_PULSE_CYC + `FILT_LEN)) begin
						cnt   <= 16'h0;
						state <= ST_LOW;
					end
				end
				ST_LOW: begin
					cnt <= cnt + 16'h1;
					if (cnt == 16'(`STEP_PULSE_CYC + `FILT_LEN)) begin
						cnt        <= 16'h0;
						steps_left <= steps_left - 16'h1;
						state      <= (steps_left == 16'h1) ? ST_IDLE : ST_HIGH;
					end
				end
				ST_RESET: begin
					cnt <= cnt + 16'h1;
					if (cnt == 16'(`RESET_PULSE_CYC + `RESET_GAP_CYC
						+ 2 * `FILT_LEN)) begin
						ctrl[6] <= 1'b0;
						state   <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	wire in_rst_pulse = (state == ST_RESET)
		&& (cnt < 16'(`RESET_PULSE_CYC + `FILT_LEN));

	always_ff @(posedge mclk) begin
		if (srst) begin
			link.step_clock            <= 1'b0;
			link.logic_reset           <= 1'b0;
			link.step_direction        <= 1'b0;
			link.step_mode_sel_0       <= 1'b0;
			link.step_mode_sel_1       <= 1'b0;
			link.step_mode_sel_2       <= 1'b0;
			link.reference_sleep_input <= 1'b0;
			link.sync_select           <= 1'b0;
		end else begin
			link.step_clock            <= (state == ST_HIGH);
			link.logic_reset           <= in_rst_pulse;
			link.step_direction        <= ctrl[3];
			link.step_mode_sel_0       <= ctrl[0];
			link.step_mode_sel_1       <= ctrl[1];
			link.step_mode_sel_2       <= ctrl[2];
			link.reference_sleep_input <= ctrl[4];
			link.sync_select           <= ctrl[5];
		end
	end
endmodule : step_host

// ===== core/step_link_if.sv
`timescale 1ns/1ps
interface step_link_if;
	logic       step_clock;
	logic       logic_reset;
	logic       step_direction;
	logic       step_mode_sel_0;
	logic       step_mode_sel_1;
	logic       step_mode_sel_2;
	logic       reference_sleep_input;
	logic       sync_select;
	logic       two_phase_monitor;
	logic       phase_a_neg;
	logic       phase_b_neg;
	logic [3:0] phase_a_code;
	logic [3:0] phase_b_code;
	modport device (
		input  step_clock, logic_reset, step_direction, step_mode_sel_0,
		input  step_mode_sel_1, step_mode_sel_2, reference_sleep_input,
		input  sync_select,
		output two_phase_monitor, phase_a_neg, phase_b_neg,
		output phase_a_code, phase_b_code
	);
	modport host (
		output step_clock, logic_reset, step_direction, step_mode_sel_0,
		output step_mode_sel_1, step_mode_sel_2, reference_sleep_input,
		output sync_select,
		input  two_phase_monitor, phase_a_neg, phase_b_neg,
		input  phase_a_code, phase_b_code
	);
endinterface : step_link_if

// ===== core/step_pkg.sv
package step_pkg;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_HIGH  = 4'b0010,
		ST_LOW   = 4'b0100,
		ST_RESET = 4'b1000
	} host_state_t;
	typedef logic [2:0] step_mode_t;
endpackage : step_pkg

// ===== core/stepper_step_sequencer.sv
`timescale 1ns/1ps
`include "step_defs.svh"
module stepper_step_sequencer
	import step_pkg::*;
#(
	parameter bit DUAL_EDGE = 1'b0
) (
	input  wire logic mclk,
	input  wire logic srst,
	step_link_if.device link,
	output logic [5:0] ring_position,
	output logic       deep_sleep,
	output logic       light_sleep
);
	localparam int NIN = 7;
	// Order: step, reset, dir, sel0, sel1, sel2, sync.
	wire  [NIN-1:0] raw_in;
	logic [NIN-1:0] sync_a;
	logic [NIN-1:0] sync_b;
	logic [NIN-1:0] filt;
	logic [5:0]     pos;
	logic           step_prev;
	logic           ref_a;
	logic           ref_b;
	step_mode_t     mode;

	assign raw_in = {link.sync_select, link.step_mode_sel_2,
		link.step_mode_sel_1, link.step_mode_sel_0, link.step_direction,
		link.logic_reset, link.step_clock};

	always_ff @(posedge mclk) begin
		if (srst) begin
			sync_a <= '0;
			sync_b <= '0;
			ref_a  <= 1'b0;
			ref_b  <= 1'b0;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			ref_a  <= link.reference_sleep_input;
			ref_b  <= ref_a;
		end
	end

	// A level is taken only after it has stood FILT_LEN cycles, so glitches
	// shorter than that never reach the sequencer; this adds latency.
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_filt
			logic [3:0] cnt;
			always_ff @(posedge mclk) begin
				if (srst) begin
					cnt          <= 4'h0;
					filt[gi]     <= 1'b0;
				end else if (sync_b[gi] == filt[gi]) begin
					cnt          <= 4'h0;
				end else if (cnt == 4'(`FILT_LEN - 1)) begin
					cnt          <= 4'h0;
					filt[gi]     <= sync_b[gi];
				end else begin
					cnt          <= cnt + 4'h1;
				end
			end
		end
	endgenerate

	wire       f_step  = filt[0];
	wire       f_reset = filt[1];
	wire       f_dir   = filt[2];
	wire [2:0] f_sel   = filt[5:3];
	wire       rise    = f_step & ~step_prev;
	wire       fall    = ~f_step & step_prev;
	wire       edge_ev = rise | (DUAL_EDGE & fall);
	wire [2:0] sel_now = rise ? f_sel : mode;
	wire       sleeping = (sel_now == `MODE_DEEP_SLEEP);

	// Step size in ring units (ring has 64 entries, one per sixteenth step).
	logic [5:0] stride;
	always_comb begin
		case (sel_now)
			`MODE_FULL_8, `MODE_FULL_F: stride = 6'h10;
			`MODE_HALF, `MODE_HALF_F:   stride = 6'h08;
			`MODE_QUARTER:              stride = 6'h04;
			`MODE_EIGHTH:               stride = 6'h02;
			default:                    stride = 6'h01;
		endcase
	end

	// Align to the new resolution's grid when the mode changes, so the
	// next position always lies on the new mode's grid.
	wire [5:0] mask     = ~(stride - 6'h01);
	wire [5:0] base_fwd = pos & mask;
	wire [5:0] base_rev = (pos + stride - 6'h01) & mask;
	wire [5:0] next_pos = f_dir ? (base_rev - stride)
		: (base_fwd + stride);

	always_ff @(posedge mclk) begin
		if (srst || f_reset) begin
			pos       <= `RING_START;
			step_prev <= 1'b0;
			mode      <= `MODE_FULL_8;
		end else begin
			step_prev <= f_step;
			if (rise)
				mode <= f_sel;
			if (edge_ev && !sleeping)
				pos <= next_pos;
		end
	end

	// The ring is 64 sixteenth steps; pos[3:0] is the offset inside one
	// full step and pos[5:4] picks which phase is crossing zero.
	logic [3:0] off16;
	logic [3:0] a_code;
	logic [3:0] b_code;
	logic       a_neg;
	logic       b_neg;
	logic       cross_neg;
	logic       full_f;
	always_comb begin
		off16  = pos[3:0];
		full_f = (mode == `MODE_FULL_F) || (mode == `MODE_HALF_F);
		// Quadrant 0: A falls 8..1, B rises 8..F, then A off.
		case (pos[5:4])
			2'h0: begin
				a_neg = 1'b0;
				b_neg = 1'b0;
			end
			2'h1: begin
				a_neg = 1'b1;
				b_neg = 1'b0;
			end
			2'h2: begin
				a_neg = 1'b1;
				b_neg = 1'b1;
			end
			default: begin
				a_neg = 1'b0;
				b_neg = 1'b1;
			end
		endcase
		// Before the swap a_code is the phase that crosses zero in this
		// full step: it falls 8..1, is off at offset 8, then climbs 1..7
		// with the opposite polarity while the other phase turns back.
		if (off16 == 4'h0) begin
			a_code = full_f ? `CODE_F : `CODE_8;
			b_code = full_f ? `CODE_F : `CODE_8;
		end else if (off16 == 4'h8) begin
			a_code = `CODE_OFF;
			b_code = `CODE_F;
		end else if (off16[3]) begin
			a_code = off16 - 4'h8;
			b_code = 4'h8 - off16;
		end else begin
			a_code = 4'h8 - off16;
			b_code = 4'h8 + off16;
		end
		cross_neg = off16[3] && (off16 != 4'h8);
		if (pos[4]) begin
			// Odd quadrants mirror: the phase that was falling now rises.
			{a_code, b_code} = {b_code, a_code};
			b_neg = b_neg ^ cross_neg;
		end else begin
			a_neg = a_neg ^ cross_neg;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || f_reset) begin
			link.phase_a_code      <= `CODE_8;
			link.phase_b_code      <= `CODE_8;
			link.phase_a_neg       <= 1'b0;
			link.phase_b_neg       <= 1'b0;
			link.two_phase_monitor <= 1'b1;
			ring_position          <= `RING_START;
			deep_sleep             <= 1'b0;
			light_sleep            <= 1'b0;
		end else begin
			link.phase_a_code      <= a_code;
			link.phase_b_code      <= b_code;
			link.phase_a_neg       <= a_neg;
			link.phase_b_neg       <= b_neg;
			link.two_phase_monitor <= (pos[3:0] == 4'h0);
			ring_position          <= pos;
			deep_sleep             <= (mode == `MODE_DEEP_SLEEP);
			light_sleep            <= ref_b;
		end
	end
endmodule : stepper_step_sequencer

// ===== verification/step_link_monitor.sv
`timescale 1ns/1ps
module step_link_monitor (
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic       step_clock,
	input wire logic       logic_reset,
	input wire logic       step_direction,
	input wire logic       step_mode_sel_0,
	input wire logic       step_mode_sel_1,
	input wire logic       step_mode_sel_2,
	input wire logic       reference_sleep_input,
	input wire logic       two_phase_monitor,
	input wire logic       phase_a_neg,
	input wire logic       phase_b_neg,
	input wire logic [3:0] phase_a_code,
	input wire logic [3:0] phase_b_code
);
	wire [2:0] mode = {step_mode_sel_2, step_mode_sel_1, step_mode_sel_0};
	wire [9:0] vec  = {phase_a_neg, phase_b_neg, phase_a_code, phase_b_code};
	wire [5:0] ins  = {logic_reset, step_direction, mode,
		reference_sleep_input};
	wire       both8 = phase_a_code == 4'h8 && phase_b_code == 4'h8;
	wire       bothf = phase_a_code == 4'hf && phase_b_code == 4'hf;
	wire       onef  = (phase_a_code == 4'h0 && phase_b_code == 4'hf)
		|| (phase_a_code == 4'hf && phase_b_code == 4'h0);
	logic [7:0] quiet;
	logic [7:0] settle;
	logic       prev_clk;
	logic       prev_rst;
	logic [5:0] prev_in;
	wire        rise = step_clock && !prev_clk;
	// The filter delays every pin but the sleep input by ten cycles, so a step only
	// counts as clean when the other inputs stood still well before it.
	wire        go   = rise && settle > 8'd20 && !logic_reset;
	wire [7:0]  next_quiet = (rise || logic_reset != prev_rst) ? 8'h00
		: quiet + {7'h00, quiet != 8'hff};
	wire [7:0]  next_settle = (ins != prev_in) ? 8'h00
		: settle + {7'h00, settle != 8'hff};
	always_ff @(posedge mclk) begin
		quiet <= srst ? 8'h00 : next_quiet;
		settle <= srst ? 8'h00 : next_settle;
		prev_clk <= step_clock;
		prev_rst <= logic_reset;
		prev_in <= ins;
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (srst);
	property p_start;
		logic_reset [*8] ##1 logic_reset [*8] |->
			both8 && !phase_a_neg && !phase_b_neg;
	endproperty
	a_start: assert property (p_start) else $error("bad reset state");
	property p_quiet;
		quiet > 8'd20 |-> $stable(vec);
	endproperty
	a_quiet: assert property (p_quiet) else $error("moved without step");
	property p_mon;
		quiet > 8'd20 |-> two_phase_monitor == (both8 || bothf);
	endproperty
	a_mon: assert property (p_mon) else $error("monitor wrong");
	property p_adv;
		go && mode != 3'h7 |-> ##[4:20] !$stable(vec);
	endproperty
	a_adv: assert property (p_adv) else $error("step not taken");
	property p_deep;
		go && mode == 3'h7 |-> $stable(vec) [*8] ##1 $stable(vec) [*8];
	endproperty
	a_deep: assert property (p_deep) else $error("moved in deep sleep");
	property p_full8;
		go && mode == 3'h0 && both8 |-> ##20 both8;
	endproperty
	a_full8: assert property (p_full8) else $error("full step off");
	property p_fullf;
		go && mode == 3'h1 && (both8 || bothf) |-> ##20 bothf;
	endproperty
	a_fullf: assert property (p_fullf) else $error("full F off");
	property p_half;
		go && mode[2:1] == 2'b01 && both8 |-> ##20 onef;
	endproperty
	a_half: assert property (p_half) else $error("half step off");
endmodule : step_link_monitor

// ===== verification/tb.sv
`timescale 1ns/1ps
`include "step_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
	logic        mclk   = 1'b0;
	logic        srst   = 1'b1;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize  = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [5:0]  ring_position;
	wire         deep_sleep;
	wire         light_sleep;
	int          n_errors = 0;
	int          checks   = 0;
	step_link_if i_step_link_if ();
	step_host i_step_host (.mclk(mclk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(i_step_link_if.host));
	stepper_step_sequencer i_stepper_step_sequencer (.mclk(mclk),
		.srst(srst), .link(i_step_link_if.device),
		.ring_position(ring_position), .deep_sleep(deep_sleep),
		.light_sleep(light_sleep));
	step_link_monitor i_step_link_monitor (.mclk(mclk), .srst(srst),
		.step_clock(i_step_link_if.step_clock),
		.logic_reset(i_step_link_if.logic_reset),
		.step_direction(i_step_link_if.step_direction),
		.step_mode_sel_0(i_step_link_if.step_mode_sel_0),
		.step_mode_sel_1(i_step_link_if.step_mode_sel_1),
		.step_mode_sel_2(i_step_link_if.step_mode_sel_2),
		.reference_sleep_input(i_step_link_if.reference_sleep_input),
		.two_phase_monitor(i_step_link_if.two_phase_monitor),
		.phase_a_neg(i_step_link_if.phase_a_neg),
		.phase_b_neg(i_step_link_if.phase_b_neg),
		.phase_a_code(i_step_link_if.phase_a_code),
		.phase_b_code(i_step_link_if.phase_b_code));
	wire [1:0] negs = {i_step_link_if.phase_a_neg, i_step_link_if.phase_b_neg};
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic do_reset;
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (30) @(posedge mclk);
	endtask : do_reset
	// Polls busy under a bound, then lets the pin filter catch up.
	task automatic step(input int n);
		int          k;
		logic [31:0] r;
		wr(`REG_STEP, 32'(n));
		repeat (4) @(posedge mclk);
		k = 0;
		do begin
			bus(1'b0, `REG_STATUS, 32'h0, r);
			k++;
		end while (r[0] !== 1'b0 && k < 2000);
		`CHK(r[0], 1'b0)
		repeat (40) @(posedge mclk);
	endtask : step
	task automatic pair(input logic [3:0] lo, input logic [3:0] hi);
		logic [3:0] a;
		logic [3:0] b;
		a = i_step_link_if.phase_a_code;
		b = i_step_link_if.phase_b_code;
		`CHK((a < b) ? {a, b} : {b, a}, {lo, hi})
	endtask : pair
	task automatic t_reset_regs;
		logic [31:0] r;
		do_reset;
		pair(4'h8, 4'h8);
		`CHK(negs, 2'b00)
		bus(1'b0, `REG_STATUS, 32'h0, r);
		`CHK(r[1:0], 2'b10)
		bus(1'b0, `REG_PHASE, 32'h0, r);
		`CHK(r, 32'h0)
	endtask : t_reset_regs
	// One step from the start point in every mode; the last entry is
	// sixteenth step with light sleep and sync select set.
	task automatic t_modes;
		logic [7:0] exp [9];
		exp = '{8'h88, 8'hff, 8'h0f, 8'h0f, 8'h4c, 8'h6a, 8'h79, 8'h88, 8'h79};
		for (int m = 0; m < 9; m++) begin
			do_reset;
			wr(`REG_CTRL, (m == 8) ? 32'h36 : 32'(m));
			repeat (30) @(posedge mclk);
			step(1);
			pair(exp[m][7:4], exp[m][3:0]);
			if (m == 0) begin
				`CHK(negs != 2'b00, 1'b1)
			end
			if (m == 7) begin
				`CHK({deep_sleep, negs}, 3'b100)
			end
			if (m == 8) begin
				`CHK(light_sleep, 1'b1)
			end
		end
	endtask : t_modes
	task automatic t_direction;
		logic [1:0] n1;
		do_reset;
		wr(`REG_CTRL, 32'h06);
		repeat (30) @(posedge mclk);
		step(1);
		pair(4'h7, 4'h9);
		n1 = negs;
		wr(`REG_CTRL, 32'h0e);
		repeat (60) @(posedge mclk);
		pair(4'h7, 4'h9);
		`CHK(negs, n1)
		step(2);
		pair(4'h7, 4'h9);
		`CHK({i_step_link_if.phase_a_code, i_step_link_if.phase_b_code}, 8'h97)
		wr(`REG_CTRL, 32'h06);
		repeat (30) @(posedge mclk);
		step(1);
		pair(4'h8, 4'h8);
		`CHK(negs, 2'b00)
		step(8);
		pair(4'h0, 4'hf);
		`CHK(i_step_link_if.two_phase_monitor, 1'b0)
		wr(`REG_CTRL, 32'h46);
		repeat (300) @(posedge mclk);
		pair(4'h8, 4'h8);
		`CHK(negs, 2'b00)
	endtask : t_direction
	task automatic give_verdict;
		if (n_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		give_verdict;
	end
	initial begin
		t_reset_regs;
		t_modes;
		t_direction;
		give_verdict;
	end
endmodule : tb
